// ---- clock_output_status_regs.sv ----
/*
 clock output and status register bank: output shaping and routing,
 rate control and phase alignment settings, identity, lock and error flags,
 programming supply enables, unlock key and memory image words.
 assumes the serial control port decoder drives the register port on CLK_SYS
 and the pll core status arrives on CLK_SYS; clock pins arrive asynchronously.
*/
// Contract
// [R1] bit-clock polarity bit inverts bit-clock output
// [R2] disable bits tristate bit-clock and frame-sync pins
// [R3] duty field selects frame-sync high time
// [R4] host keeps frame pulse within half frame
// [R5] frame-sync polarity bit inverts frame-sync output
// [R6] first aux field routes eight sources
// [R7] second aux field: off, unlocks, missing
// [R8] main source: master or alternate clocks
// [R9] rate-control enable bit turns rate control on
// [R10] rate-control bit-clock rate field passed on
// [R11] rate-control master rate field passed on
// [R12] stability bit waits for stable offset
// [R13] writing one to kick starts alignment once
// [R14] speed field limits frame stretch per cycle
// [R15] automatic alignment above two times two-to-n
// [R16] identifier register returns fixed part code
// [R17] revision register returns two revision counts
// [R18] live unlock bits plus write-one-clear sticky copies
// [R19] eight latching write-one-clear error flags
// [R20] three independent supply enables, off at reset
// [R21] 0xAA then 0x55 unlocks the key
// [R22] any other key byte locks again
// [R23] image words hold two bytes, reset zero
// [R24] reserved bits read zero, ignore writes; output_config_one bits 15:8 are stored and read back as written
`timescale 1ns/100ps
`default_nettype none
`include "clock_output_status_defines.svh"

module clock_output_status_regs #(
   parameter logic [15:0] PART_CODE = 16'h5A3C,
   parameter logic [7:0] REVISION = 8'h11
) (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic IMG_LOAD,
   input wire logic [2:0] IMG_INDEX,
   input wire logic [15:0] IMG_DATA,
   input wire clock_output_status_pkg::clock_taps_t CLK_TAPS,
   input wire clock_output_status_pkg::core_status_t CORE_STATUS,
   output clock_output_status_pkg::core_control_t CORE_CONTROL,
   output logic BIT_CLOCK_O,
   output logic BIT_CLOCK_OE,
   output logic FRAME_PULSE_O,
   output logic FRAME_PULSE_OE,
   output logic FIRST_AUX_PIN,
   output logic SECOND_AUX_PIN,
   output logic MAIN_PIN
);

   clock_output_status_pkg::bank_state_t s_reg;
   clock_output_status_pkg::bank_state_t s_next;
   clock_output_status_pkg::clock_taps_t taps;
   logic [2:0] width_code;
   logic [2:0] aux_one;
   logic [1:0] aux_two;
   logic [1:0] main_src;
   logic [2:0] thr_code;
   logic [8:0] threshold;
   logic input_clock;
   logic main_clock;
   logic bit_edge;
   logic frame_edge;
   logic wr_hit_key;
   logic [15:0] lock_word;
   logic [3:0] img_slot;
   logic img_hit;

   always_comb begin
      taps = s_reg.sync_second;
      width_code = s_reg.output_config_one[`FRAME_WIDTH_HI:`FRAME_WIDTH_LO];
      aux_one = s_reg.output_config_two[`FIRST_AUX_HI:`FIRST_AUX_LO];
      aux_two = s_reg.output_config_two[`SECOND_AUX_HI:`SECOND_AUX_LO];
      main_src = s_reg.output_config_two[`MAIN_SOURCE_HI:`MAIN_SOURCE_LO];
      thr_code = s_reg.phase_align_config[`ALIGN_THRESHOLD_HI:`ALIGN_THRESHOLD_LO];
      threshold = `THRESHOLD_BASE << thr_code; // [R15]
      input_clock = taps.input_clock ^ s_reg.output_config_two[`INPUT_CLOCK_POLARITY];
      bit_edge = taps.bit_clock_raw & ~s_reg.sync_prev[5];
      frame_edge = taps.frame_pulse_raw & ~s_reg.sync_prev[6];
      wr_hit_key = REG_WR && (REG_ADDR == `ADDR_UNLOCK_KEY);
      img_slot = 4'(REG_ADDR[4:1]);
      img_hit = (REG_ADDR >= `ADDR_IMAGE_FIRST) && (REG_ADDR <= `ADDR_IMAGE_LAST)
         && !REG_ADDR[0];
      lock_word = {12'h000, s_reg.lock_lost_latched[1], CORE_STATUS.phase_lock_lost,
         s_reg.lock_lost_latched[0], CORE_STATUS.freq_lock_lost};
      case (main_src)
         2'b00: main_clock = taps.master_clock; // [R8]
         2'b10: main_clock = taps.alt_clock_low; // [R8]
         2'b11: main_clock = taps.alt_clock_high; // [R8]
         default: main_clock = 1'b0;
      endcase
   end

   always_comb begin
      s_next = s_reg;
      s_next.sync_first = CLK_TAPS;
      s_next.sync_second = s_reg.sync_first;
      s_next.sync_prev = s_reg.sync_second;
      s_next.read_valid = 1'b0;
      s_next.align_start = 1'b0;

      // frame pulse shaping on bit-clock rising edges
      if (width_code == 3'b000 || width_code == 3'b111) begin
         s_next.frame_pulse = taps.frame_pulse_raw; // [R3]
         s_next.frame_count = 6'h00;
      end else if (frame_edge) begin
         s_next.frame_pulse = 1'b1; // [R3]
         s_next.frame_count = 6'(6'h01 << (width_code - 3'b001)); // [R3]
      end else if (bit_edge && s_reg.frame_pulse) begin
         if (s_reg.frame_count <= 6'h01) begin
            s_next.frame_pulse = 1'b0; // [R3]
            s_next.frame_count = 6'h00;
         end else begin
            s_next.frame_count = s_reg.frame_count - 6'h01;
         end
      end

      s_next.bit_clock_pin = taps.bit_clock_raw
         ^ s_reg.output_config_one[`BIT_CLOCK_POLARITY]; // [R1]
      s_next.frame_pulse_pin = s_reg.frame_pulse
         ^ s_reg.output_config_one[`FRAME_PULSE_POLARITY]; // [R5]
      s_next.main_pin = main_clock ^ s_reg.output_config_two[`MAIN_OUTPUT_POLARITY];
      case (aux_one)
         3'b000: s_next.first_aux_pin = taps.reference_clock; // [R6]
         3'b001: s_next.first_aux_pin = input_clock; // [R6]
         3'b010: s_next.first_aux_pin = s_reg.main_pin; // [R6]
         3'b011: s_next.first_aux_pin = CORE_STATUS.freq_lock_lost; // [R6]
         3'b100: s_next.first_aux_pin = CORE_STATUS.phase_lock_lost; // [R6]
         3'b101: s_next.first_aux_pin = s_reg.bit_clock_pin; // [R6]
         3'b110: s_next.first_aux_pin = s_reg.frame_pulse_pin; // [R6]
         default: s_next.first_aux_pin = CORE_STATUS.input_clock_missing; // [R6]
      endcase
      case (aux_two)
         2'b01: s_next.second_aux_pin = CORE_STATUS.freq_lock_lost; // [R7]
         2'b10: s_next.second_aux_pin = CORE_STATUS.phase_lock_lost; // [R7]
         2'b11: s_next.second_aux_pin = CORE_STATUS.input_clock_missing; // [R7]
         default: s_next.second_aux_pin = 1'b0; // [R7]
      endcase

      // automatic alignment start
      if (s_reg.phase_align_config[`ALIGN_ENABLE]
            && !s_reg.phase_align_config[`ALIGN_MANUAL]
            && ({1'b0, CORE_STATUS.phase_offset} > {1'b0, threshold}) // [R15]
            && (!s_reg.phase_align_config[`ALIGN_WAIT_STABLE]
               || CORE_STATUS.offset_stable)) begin // [R12]
         s_next.align_start = 1'b1;
      end

      // register writes
      if (REG_WR) begin
         case (REG_ADDR)
            `ADDR_OUTPUT_CONFIG_ONE:
               s_next.output_config_one = REG_WDATA & `MASK_OUTPUT_CONFIG_ONE; // [R24]
            `ADDR_OUTPUT_CONFIG_TWO:
               s_next.output_config_two = REG_WDATA & `MASK_OUTPUT_CONFIG_TWO; // [R24]
            `ADDR_RATE_CONTROL_CONFIG:
               s_next.rate_control_config = REG_WDATA & `MASK_RATE_CONTROL_CONFIG;
            `ADDR_PHASE_ALIGN_CONFIG: begin
               s_next.phase_align_config = REG_WDATA & `MASK_PHASE_ALIGN_CONFIG;
               if (REG_WDATA[`ALIGN_KICK] && REG_WDATA[`ALIGN_MANUAL]
                     && REG_WDATA[`ALIGN_ENABLE]) begin
                  s_next.align_start = 1'b1; // [R13]
               end
            end
            `ADDR_LOCK_LOSS_FLAGS: begin
               if (REG_WDATA[`FREQ_LOCK_LOST_LATCHED]) begin
                  s_next.lock_lost_latched[0] = 1'b0; // [R18]
               end
               if (REG_WDATA[`PHASE_LOCK_LOST_LATCHED]) begin
                  s_next.lock_lost_latched[1] = 1'b0; // [R18]
               end
            end
            `ADDR_ERROR_FLAGS:
               s_next.error_flags = s_reg.error_flags & ~REG_WDATA[7:0]; // [R19]
            `ADDR_PROG_SUPPLY_CONTROL:
               s_next.prog_supply_control = REG_WDATA & `MASK_PROG_SUPPLY_CONTROL; // [R20]
            default: begin
               if (img_hit) begin
                  s_next.image[img_slot] = REG_WDATA; // [R23]
               end
            end
         endcase
      end

      // key sequence
      if (wr_hit_key) begin
         if (REG_WDATA[7:0] == `KEY_FIRST) begin
            s_next.key_state = clock_output_status_pkg::KEY_HALF; // [R21]
         end else if (REG_WDATA[7:0] == `KEY_SECOND
               && s_reg.key_state == clock_output_status_pkg::KEY_HALF) begin
            s_next.key_state = clock_output_status_pkg::KEY_OPEN; // [R21]
         end else begin
            s_next.key_state = clock_output_status_pkg::KEY_LOCKED; // [R22]
         end
      end

      // memory image load from the programmable memory side wins over the host
      if (IMG_LOAD && IMG_INDEX < 3'(`IMAGE_WORDS)) begin
         s_next.image[IMG_INDEX] = IMG_DATA; // [R23]
      end

      // hardware sets win over software clears
      s_next.lock_lost_latched = s_next.lock_lost_latched
         | {CORE_STATUS.phase_lock_lost, CORE_STATUS.freq_lock_lost}; // [R18]
      s_next.error_flags = s_next.error_flags | CORE_STATUS.fault_events; // [R19]

      // register reads
      if (REG_RD) begin
         s_next.read_valid = 1'b1;
         case (REG_ADDR)
            `ADDR_OUTPUT_CONFIG_ONE: s_next.read_data = s_reg.output_config_one;
            `ADDR_OUTPUT_CONFIG_TWO: s_next.read_data = s_reg.output_config_two;
            `ADDR_RATE_CONTROL_CONFIG: s_next.read_data = s_reg.rate_control_config;
            `ADDR_PHASE_ALIGN_CONFIG: s_next.read_data = s_reg.phase_align_config;
            `ADDR_PART_IDENTIFIER: s_next.read_data = PART_CODE; // [R16]
            `ADDR_SILICON_REVISION: s_next.read_data = {8'h00, REVISION}; // [R17]
            `ADDR_LOCK_LOSS_FLAGS: s_next.read_data = lock_word; // [R18]
            `ADDR_ERROR_FLAGS: s_next.read_data = {8'h00, s_reg.error_flags};
            `ADDR_PROG_SUPPLY_CONTROL: s_next.read_data = s_reg.prog_supply_control;
            default: begin
               if (img_hit) begin
                  s_next.read_data = s_reg.image[img_slot]; // [R23]
               end else begin
                  s_next.read_data = 16'h0000; // [R24]
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      REG_RDATA = s_reg.read_data;
      REG_RVALID = s_reg.read_valid;
      BIT_CLOCK_O = s_reg.bit_clock_pin;
      BIT_CLOCK_OE = !s_reg.output_config_one[`BIT_CLOCK_PIN_OFF]; // [R2]
      FRAME_PULSE_O = s_reg.frame_pulse_pin;
      FRAME_PULSE_OE = !s_reg.output_config_one[`FRAME_PULSE_PIN_OFF]; // [R2]
      FIRST_AUX_PIN = s_reg.first_aux_pin;
      SECOND_AUX_PIN = s_reg.second_aux_pin;
      MAIN_PIN = s_reg.main_pin;
      CORE_CONTROL.rate_control_on = s_reg.rate_control_config[`RATE_CONTROL_ON]; // [R9]
      CORE_CONTROL.rate_control_bit_clock_rate =
         s_reg.rate_control_config[`RATE_BIT_CLOCK_HI:`RATE_BIT_CLOCK_LO]; // [R10]
      CORE_CONTROL.rate_control_master_rate =
         s_reg.rate_control_config[`RATE_MASTER_HI:`RATE_MASTER_LO]; // [R11]
      CORE_CONTROL.align_enable = s_reg.phase_align_config[`ALIGN_ENABLE];
      CORE_CONTROL.align_start = s_reg.align_start;
      case (s_reg.phase_align_config[`ALIGN_SPEED_HI:`ALIGN_SPEED_LO])
         2'b00: CORE_CONTROL.stretch_limit = `STRETCH_ONE; // [R14]
         2'b01: CORE_CONTROL.stretch_limit = `STRETCH_TEN; // [R14]
         2'b10: CORE_CONTROL.stretch_limit = `STRETCH_FIFTY; // [R14]
         default: CORE_CONTROL.stretch_limit = `STRETCH_MAX; // [R14]
      endcase
      CORE_CONTROL.align_threshold = threshold;
      CORE_CONTROL.prog_supply_on = s_reg.prog_supply_control[`PROG_SUPPLY_ON]; // [R20]
      CORE_CONTROL.regulator_discharge_on =
         s_reg.prog_supply_control[`REGULATOR_DISCHARGE_ON]; // [R20]
      CORE_CONTROL.prog_regulator_on = s_reg.prog_supply_control[`PROG_REGULATOR_ON]; // [R20]
      CORE_CONTROL.key_open = (s_reg.key_state == clock_output_status_pkg::KEY_OPEN);
   end

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   a_bit_clock_polarity: assert property ( // [R1]
      BIT_CLOCK_O == ($past(taps.bit_clock_raw)
         ^ $past(s_reg.output_config_one[`BIT_CLOCK_POLARITY])))
      else $error("bit clock polarity wrong");

   a_frame_pin_off: assert property ( // [R2]
      (REG_WR && REG_ADDR == `ADDR_OUTPUT_CONFIG_ONE && REG_WDATA[`FRAME_PULSE_PIN_OFF])
         |=> !FRAME_PULSE_OE)
      else $error("frame pin not released");

   a_aux_two_off: assert property ( // [R7]
      (aux_two == 2'b00) |=> !SECOND_AUX_PIN)
      else $error("second aux driven while off");

   a_kick_start: assert property ( // [R13]
      (REG_WR && REG_ADDR == `ADDR_PHASE_ALIGN_CONFIG && REG_WDATA[`ALIGN_KICK]
         && REG_WDATA[`ALIGN_MANUAL] && REG_WDATA[`ALIGN_ENABLE])
         |=> CORE_CONTROL.align_start ##1 !CORE_CONTROL.align_start || REG_WR)
      else $error("kick did not start one alignment");

   a_stable_wait: assert property ( // [R12]
      CORE_CONTROL.align_start && $past(s_reg.phase_align_config[`ALIGN_WAIT_STABLE])
         && !$past(s_reg.phase_align_config[`ALIGN_MANUAL])
         |-> $past(CORE_STATUS.offset_stable))
      else $error("alignment started on unstable offset");

   a_part_code: assert property ( // [R16]
      (REG_RD && REG_ADDR == `ADDR_PART_IDENTIFIER) |=> REG_RVALID && REG_RDATA == PART_CODE)
      else $error("part code read wrong");

   a_sticky_set: assert property ( // [R18]
      CORE_STATUS.freq_lock_lost |=> s_reg.lock_lost_latched[0])
      else $error("frequency sticky flag lost");

   a_error_hold: assert property ( // [R19]
      s_reg.error_flags[7] && !(REG_WR && REG_ADDR == `ADDR_ERROR_FLAGS && REG_WDATA[7])
         |=> s_reg.error_flags[7])
      else $error("error flag cleared without write");

   a_key_unlock: assert property ( // [R21]
      (wr_hit_key && REG_WDATA[7:0] == `KEY_SECOND
         && s_reg.key_state == clock_output_status_pkg::KEY_HALF) |=> CORE_CONTROL.key_open)
      else $error("key not opened by sequence");

   a_key_relock: assert property ( // [R22]
      (wr_hit_key && REG_WDATA[7:0] != `KEY_FIRST && REG_WDATA[7:0] != `KEY_SECOND)
         |=> !CORE_CONTROL.key_open)
      else $error("key still open after other byte");

   a_reserved_zero: assert property ( // [R24]
      REG_RVALID && $past(REG_ADDR) == `ADDR_RATE_CONTROL_CONFIG |-> REG_RDATA[15:7] == 9'h000)
      else $error("reserved bits read nonzero");

endmodule : clock_output_status_regs
`default_nettype wire

// ---- clock_output_status_defines.svh ----
/*
 register offsets, field positions, reset values and fixed codes of the
 clock output and status register bank.
 assumes 16-bit register addresses and 16-bit register data.
*/
`ifndef CLOCK_OUTPUT_STATUS_DEFINES_SVH
`define CLOCK_OUTPUT_STATUS_DEFINES_SVH

// register addresses
`define ADDR_OUTPUT_CONFIG_ONE 16'h0106
`define ADDR_OUTPUT_CONFIG_TWO 16'h0108
`define ADDR_RATE_CONTROL_CONFIG 16'h0112
`define ADDR_PHASE_ALIGN_CONFIG 16'h0114
`define ADDR_PART_IDENTIFIER 16'h0120
`define ADDR_SILICON_REVISION 16'h0122
`define ADDR_LOCK_LOSS_FLAGS 16'h0124
`define ADDR_ERROR_FLAGS 16'h0126
`define ADDR_PROG_SUPPLY_CONTROL 16'h0128
`define ADDR_UNLOCK_KEY 16'h0200
`define ADDR_IMAGE_FIRST 16'h2300
`define ADDR_IMAGE_LAST 16'h230A
`define IMAGE_WORDS 6

// writable bit masks, reserved bits read zero
`define MASK_OUTPUT_CONFIG_ONE 16'hFFDF
`define MASK_OUTPUT_CONFIG_TWO 16'h9F0E
`define MASK_RATE_CONTROL_CONFIG 16'h007F
`define MASK_PHASE_ALIGN_CONFIG 16'h80DF
`define MASK_PROG_SUPPLY_CONTROL 16'h000B
`define RESET_VALUE 16'h0000

// output_config_one fields
`define BIT_CLOCK_POLARITY 7
`define BIT_CLOCK_PIN_OFF 6
`define FRAME_WIDTH_HI 4
`define FRAME_WIDTH_LO 2
`define FRAME_PULSE_POLARITY 1
`define FRAME_PULSE_PIN_OFF 0

// output_config_two fields
`define INPUT_CLOCK_POLARITY 15
`define FIRST_AUX_HI 12
`define FIRST_AUX_LO 10
`define SECOND_AUX_HI 9
`define SECOND_AUX_LO 8
`define MAIN_SOURCE_HI 3
`define MAIN_SOURCE_LO 2
`define MAIN_OUTPUT_POLARITY 1

// rate_control_config fields
`define RATE_CONTROL_ON 6
`define RATE_BIT_CLOCK_HI 5
`define RATE_BIT_CLOCK_LO 2
`define RATE_MASTER_HI 1
`define RATE_MASTER_LO 0

// phase_align_config fields
`define ALIGN_ENABLE 15
`define ALIGN_WAIT_STABLE 7
`define ALIGN_MANUAL 6
`define ALIGN_KICK 5
`define ALIGN_SPEED_HI 4
`define ALIGN_SPEED_LO 3
`define ALIGN_THRESHOLD_HI 2
`define ALIGN_THRESHOLD_LO 0

// lock_loss_flags fields
`define PHASE_LOCK_LOST_LATCHED 3
`define PHASE_LOCK_LOST 2
`define FREQ_LOCK_LOST_LATCHED 1
`define FREQ_LOCK_LOST 0

// prog_supply_control fields
`define PROG_SUPPLY_ON 3
`define REGULATOR_DISCHARGE_ON 1
`define PROG_REGULATOR_ON 0

// unlock key bytes
`define KEY_FIRST 8'hAA
`define KEY_SECOND 8'h55

// stretch limits in master-clock periods, maximum shown as all ones
`define STRETCH_ONE 8'h01
`define STRETCH_TEN 8'h0A
`define STRETCH_FIFTY 8'h32
`define STRETCH_MAX 8'hFF
`define THRESHOLD_BASE 9'h002

`endif

// ---- clock_output_status_pkg.sv ----
/*
 types of the clock output and status register bank.
 assumes nothing beyond a SystemVerilog compiler.
*/
package clock_output_status_pkg;

   typedef enum logic [1:0] {
      KEY_LOCKED = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } key_state_t;

   // sampled clock pins, all asynchronous to the system clock
   typedef struct packed {
      logic frame_pulse_raw;
      logic bit_clock_raw;
      logic alt_clock_high;
      logic alt_clock_low;
      logic master_clock;
      logic input_clock;
      logic reference_clock;
   } clock_taps_t;

   // status from the pll core, on the system clock
   typedef struct packed {
      logic freq_lock_lost;
      logic phase_lock_lost;
      logic input_clock_missing;
      logic [7:0] fault_events;
      logic [9:0] phase_offset;
      logic offset_stable;
   } core_status_t;

   // settings to the pll core
   typedef struct packed {
      logic rate_control_on;
      logic [3:0] rate_control_bit_clock_rate;
      logic [1:0] rate_control_master_rate;
      logic align_enable;
      logic align_start;
      logic [7:0] stretch_limit;
      logic [8:0] align_threshold;
      logic prog_supply_on;
      logic regulator_discharge_on;
      logic prog_regulator_on;
      logic key_open;
   } core_control_t;

   typedef struct packed {
      logic [15:0] output_config_one;
      logic [15:0] output_config_two;
      logic [15:0] rate_control_config;
      logic [15:0] phase_align_config;
      logic [1:0] lock_lost_latched;
      logic [7:0] error_flags;
      logic [15:0] prog_supply_control;
      key_state_t key_state;
      logic [5:0][15:0] image;
      logic [6:0] sync_first;
      logic [6:0] sync_second;
      logic [6:0] sync_prev;
      logic frame_pulse;
      logic [5:0] frame_count;
      logic align_start;
      logic bit_clock_pin;
      logic frame_pulse_pin;
      logic first_aux_pin;
      logic second_aux_pin;
      logic main_pin;
      logic [15:0] read_data;
      logic read_valid;
   } bank_state_t;

endpackage : clock_output_status_pkg

// ---- host_model.sv ----
/*
 host processor model on the register port of the bank.
 assumes CLK_SYS and one strobe for each transfer.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic CLK_SYS,
   output logic [15:0] REG_ADDR,
   output logic [15:0] REG_WDATA,
   output logic REG_WR,
   output logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic REG_RVALID
);
   initial begin
      REG_ADDR = 16'h0000;
      REG_WDATA = 16'h0000;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end
   // released lines show the inverse, never the last value
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      REG_ADDR <= ~a;
      REG_WDATA <= ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      REG_ADDR <= ~a;
      #1;
      d = REG_RDATA;
      v = REG_RVALID;
   endtask : rd
endmodule : host_model
`default_nettype wire

// ---- clock_output_status_regs_tb_top.sv ----
/*
 self-checking bench of the clock output and status bank.
 assumes the host model on the register port.
*/
`timescale 1ns/100ps
`default_nettype none
module clock_output_status_regs_tb_top;
   localparam logic [15:0] PART = 16'h3C5A; // arbitrary value
   localparam logic [7:0] REV = 8'h23; // arbitrary value
   logic CLK_SYS, RESETN, REG_WR, REG_RD, REG_RVALID, IMG_LOAD, v;
   logic BIT_CLOCK_O, BIT_CLOCK_OE, FRAME_PULSE_O, FRAME_PULSE_OE;
   logic FIRST_AUX_PIN, SECOND_AUX_PIN, MAIN_PIN;
   logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, IMG_DATA, d, e;
   logic [2:0] IMG_INDEX;
   clock_output_status_pkg::clock_taps_t CLK_TAPS;
   clock_output_status_pkg::core_status_t CORE_STATUS;
   clock_output_status_pkg::core_control_t CORE_CONTROL;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 32'h642b;
   int n;
   int mdl[int];
   logic [15:0] al[16] = '{16'h0106, 16'h0108, 16'h0112, 16'h0114, 16'h0120, 16'h0122,
      16'h0124, 16'h0126, 16'h0128, 16'h0200, 16'h2300, 16'h2302, 16'h2304, 16'h230A,
      16'h0300, 16'h0107};
   logic [7:0] kb[8] = '{8'hAA, 8'h55, 8'h12, 8'h55, 8'hAA, 8'hAA, 8'h55, 8'h00};
   logic [7:0] ko = 8'b0100_0010;
   logic [7:0] sl[4] = '{8'h01, 8'h0A, 8'h32, 8'hFF};
   logic [2:0] a1[4] = '{3'h3, 3'h4, 3'h7, 3'h3};
   logic [1:0] mc[4] = '{2'h0, 2'h2, 2'h3, 2'h0};
   logic [3:0] hit = 4'b1101;
   logic [15:0] ac[4] = '{16'h8080, 16'h8080, 16'h8080, 16'h8000};
   logic [9:0] po[4] = '{10'h003, 10'h003, 10'h002, 10'h003};
   logic [3:0] os = 4'b0010;
   logic [15:0] ex[4] = '{16'h0000, 16'h0004, 16'h0000, 16'h0004};
   clock_output_status_regs #(.PART_CODE(PART), .REVISION(REV)) clock_output_status_regs_i (
      .CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .IMG_LOAD(IMG_LOAD), .IMG_INDEX(IMG_INDEX), .IMG_DATA(IMG_DATA), .CLK_TAPS(CLK_TAPS),
      .CORE_STATUS(CORE_STATUS), .CORE_CONTROL(CORE_CONTROL), .BIT_CLOCK_O(BIT_CLOCK_O),
      .BIT_CLOCK_OE(BIT_CLOCK_OE), .FRAME_PULSE_O(FRAME_PULSE_O),
      .FRAME_PULSE_OE(FRAME_PULSE_OE), .FIRST_AUX_PIN(FIRST_AUX_PIN),
      .SECOND_AUX_PIN(SECOND_AUX_PIN), .MAIN_PIN(MAIN_PIN));
   host_model host_model_i (.CLK_SYS(CLK_SYS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   task automatic rchk(input logic [15:0] a);
      host_model_i.rd(a, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, mdl.exists(a) ? 16'(mdl[a]) : 16'h0000);
   endtask : rchk
   task automatic w(input logic [15:0] a, input logic [15:0] x, input logic [15:0] m);
      host_model_i.wr(a, x);
      mdl[a] = x & m;
   endtask : w
   task automatic cyc(input int k);
      repeat (k) @(posedge CLK_SYS);
      #1;
   endtask : cyc
   task automatic pcount();
      n = 0;
      repeat (4) begin
         #1;
         n += (CORE_CONTROL.align_start === 1'b1);
         @(posedge CLK_SYS);
      end
   endtask : pcount
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      RESETN = 1'b0;
      IMG_LOAD = 1'b0;
      IMG_INDEX = 3'h0;
      IMG_DATA = 16'h0000;
      CLK_TAPS = '0;
      CORE_STATUS = '0;
      mdl[16'h0120] = PART;
      mdl[16'h0122] = {8'h00, REV};
      mdl[16'h0126] = 0;
      repeat (5) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      foreach (al[i]) rchk(al[i]);
      for (int i = 0; i < 7; i++) begin
         e = 16'($random(seed));
         @(posedge CLK_SYS);
         IMG_LOAD <= 1'b1;
         IMG_INDEX <= i[2:0];
         IMG_DATA <= e;
         @(posedge CLK_SYS);
         IMG_LOAD <= 1'b0;
         if (i < 6) mdl[16'h2300 + 2 * i] = e;
      end
      repeat (3) begin
         w(16'h0106, 16'($random(seed)), 16'hFFDF);
         w(16'h0108, 16'($random(seed)), 16'h9F0E);
         w(16'h0112, 16'($random(seed)), 16'h007F);
         w(16'h0128, 16'($random(seed)), 16'h000B);
         w(16'h2302, 16'($random(seed)), 16'hFFFF);
         host_model_i.wr(16'h0120, 16'($random(seed)));
         host_model_i.wr(16'h0300, 16'($random(seed)));
         #1;
         e = {9'h000, CORE_CONTROL.rate_control_on, CORE_CONTROL.rate_control_bit_clock_rate,
            CORE_CONTROL.rate_control_master_rate};
         chk(e, 16'(mdl[16'h0112]));
         e = {12'h000, CORE_CONTROL.prog_supply_on, 1'b0, CORE_CONTROL.regulator_discharge_on,
            CORE_CONTROL.prog_regulator_on};
         chk(e, 16'(mdl[16'h0128]));
      end
      foreach (al[i]) rchk(al[i]);
      for (int k = 0; k < 8; k++) begin
         w(16'h0106, {8'h00, k[0], k[2], 4'h0, k[0], k[2]}, 16'hFFDF);
         CLK_TAPS.bit_clock_raw <= k[1];
         CLK_TAPS.frame_pulse_raw <= k[1];
         cyc(5);
         e = {12'h000, k[1] ^ k[0], k[1] ^ k[0], !k[2], !k[2]};
         chk({12'h000, BIT_CLOCK_O, FRAME_PULSE_O, BIT_CLOCK_OE, FRAME_PULSE_OE}, e);
      end
      CORE_STATUS.freq_lock_lost <= 1'b1;
      CORE_STATUS.phase_lock_lost <= 1'b1;
      cyc(3);
      mdl[16'h0124] = 16'h000F;
      rchk(16'h0124);
      @(posedge CLK_SYS);
      CORE_STATUS.freq_lock_lost <= 1'b0;
      CORE_STATUS.phase_lock_lost <= 1'b0;
      cyc(3);
      w(16'h0124, 16'h0002, 16'h0000);
      mdl[16'h0124] = 16'h0008;
      rchk(16'h0124);
      w(16'h0124, 16'h0008, 16'h0000);
      rchk(16'h0124);
      repeat (2) begin
         e = 16'($random(seed)) & 16'h00FF;
         @(posedge CLK_SYS);
         CORE_STATUS.fault_events <= e[7:0];
         @(posedge CLK_SYS);
         CORE_STATUS.fault_events <= 8'h00;
         cyc(2);
         mdl[16'h0126] = (mdl[16'h0126] | e) & 16'h00FF;
         rchk(16'h0126);
         host_model_i.wr(16'h0126, e & 16'h000F);
         mdl[16'h0126] = mdl[16'h0126] & ~(e & 16'h000F);
         rchk(16'h0126);
      end
      @(posedge CLK_SYS);
      CORE_STATUS.freq_lock_lost <= 1'b1;
      CORE_STATUS.input_clock_missing <= 1'b1;
      CLK_TAPS.master_clock <= 1'b1;
      CLK_TAPS.alt_clock_high <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         w(16'h0108, {3'h0, a1[k], k[1:0], 4'h0, mc[k], 2'h0}, 16'h9F0E);
         cyc(6);
         e = {13'h0000, hit[k], k[0], hit[k]};
         chk({13'h0000, FIRST_AUX_PIN, SECOND_AUX_PIN, MAIN_PIN}, e);
      end
      for (int i = 0; i < 8; i++) begin
         host_model_i.wr(16'h0200, {8'h00, kb[i]});
         cyc(1);
         chk({15'h0000, CORE_CONTROL.key_open}, {15'h0000, ko[i]});
      end
      host_model_i.wr(16'h0114, 16'h8060);
      pcount();
      chk(16'(n), 16'h0001);
      w(16'h0114, 16'h8040, 16'h80DF);
      pcount();
      chk(16'(n), 16'h0000);
      rchk(16'h0114);
      for (int c = 0; c < 8; c++) begin
         w(16'h0114, {11'h000, c[1:0], c[2:0]}, 16'h80DF);
         #1;
         chk({7'h00, CORE_CONTROL.align_threshold}, 16'(2 << c));
         chk({8'h00, CORE_CONTROL.stretch_limit}, {8'h00, sl[c[1:0]]});
      end
      for (int i = 0; i < 4; i++) begin
         w(16'h0114, ac[i], 16'h80DF);
         CORE_STATUS.phase_offset <= po[i];
         CORE_STATUS.offset_stable <= os[i];
         cyc(3);
         pcount();
         chk(16'(n), ex[i]);
      end
      summarize();
   end
endmodule : clock_output_status_regs_tb_top
`default_nettype wire
